// file: design/otp_dev.sv
// Device end: link slave, memory access registers and code memory
`timescale 1ns/1ps
module otp_dev (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Link
  otp_link_if.dev   lnk,
  // Core side
  output logic      core_halt_o,
  output logic      prog_mode_o,
  output logic      sys_reset_o
);
  typedef enum logic [1:0] {lk_idle, lk_ins, lk_wr, lk_rd} otp_lk_t;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [3:0] sy1_ff;
  logic [3:0] sy2_ff;
  logic       clk_prev_ff;
  logic       s_clk;
  logic       s_dat;
  logic       s_vpp;
  logic       s_rstn;
  logic       rise;
  logic       fall;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sy1_ff      <= 4'hF;
      sy2_ff      <= 4'hF;
      clk_prev_ff <= 1'b0;
    end else begin
      sy1_ff      <= {lnk.link_clk, lnk.dat, lnk.vpp, lnk.rst_pin_n};
      sy2_ff      <= sy1_ff;
      clk_prev_ff <= sy2_ff[3];
    end
  end

  assign s_clk  = sy2_ff[3];
  assign s_dat  = sy2_ff[2];
  assign s_vpp  = sy2_ff[1];
  assign s_rstn = sy2_ff[0];
  assign rise   = s_clk & ~clk_prev_ff;
  assign fall   = ~s_clk & clk_prev_ff;

  // ****************************************
  // Code memory
  // ****************************************
  logic [7:0]              mem [0:(1 << otp_pkg::ADDR_W) - 1];
  logic                    mem_we;
  logic [otp_pkg::ADDR_W-1:0] mem_wa;
  logic [7:0]              mem_wd;
  logic [7:0]              mem_rd;
  logic [7:0]              sec;
  logic                    wlock;
  logic                    rlock;

  initial begin
    for (int i = 0; i < (1 << otp_pkg::ADDR_W); i++) begin
      mem[i] = otp_pkg::ERASED;
    end
  end

  // No erase path: cells are only ever written once from erased
  always_ff @(posedge clk_i) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  assign sec    = mem[otp_pkg::SEC_ADDR];
  assign wlock  = ~&sec[7:4];
  assign rlock  = ~&sec[3:0];

  // ****************************************
  // Link engine and registers
  // ****************************************
  otp_lk_t           lk_ff, nxt_lk;
  otp_pkg::otp_mode_t mode_ff, nxt_mode;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic [7:0]  sh_ff, nxt_sh;
  logic [1:0]  ins_ff, nxt_ins;
  logic [7:0]  sel_ff, nxt_sel;
  logic [7:0]  device_control_reg_ff, nxt_device_control_reg;
  logic        last02_ff, nxt_last02;
  logic [15:0] addr_ff, nxt_addr;
  logic        err_ff, nxt_err;
  logic [7:0]  busy_ff, nxt_busy;
  logic        halt_ff, nxt_halt;
  logic        sysrst_ff, nxt_sysrst;
  logic        dout_ff, nxt_dout;
  logic        doe_n_ff, nxt_doe_n;
  logic        pmode_ff, nxt_pmode;
  logic [7:0]  wb;
  logic [7:0]  rb;
  logic [1:0]  ins2;
  logic        in_rng;
  logic        wr_ok;
  logic        rd_ok;

  assign mem_rd = mem[addr_ff[otp_pkg::ADDR_W-1:0]];
  assign in_rng = (addr_ff < otp_pkg::CODE_BYTES);
  assign mem_wa = addr_ff[otp_pkg::ADDR_W-1:0];
  assign wr_ok  = halt_ff && (mode_ff == otp_pkg::md_prog) && s_vpp && !wlock && in_rng
                  && (busy_ff == 8'h00) && (mem_rd == otp_pkg::ERASED);
  assign rd_ok  = halt_ff && !rlock && in_rng && (busy_ff == 8'h00);

  always_comb begin
    nxt_lk     = lk_ff;
    nxt_mode   = mode_ff;
    nxt_cnt    = cnt_ff;
    nxt_sh     = sh_ff;
    nxt_ins    = ins_ff;
    nxt_sel    = sel_ff;
    nxt_device_control_reg = device_control_reg_ff;
    nxt_last02 = last02_ff;
    nxt_addr   = addr_ff;
    nxt_err    = err_ff;
    nxt_busy   = busy_ff;
    nxt_halt   = halt_ff;
    nxt_sysrst = 1'b0;
    nxt_dout   = dout_ff;
    nxt_doe_n  = doe_n_ff;
    mem_we     = 1'b0;
    mem_wd     = otp_pkg::ERASED;
    wb         = {sh_ff[6:0], s_dat};
    ins2       = {ins_ff[0], s_dat};
    rb         = 8'h00;
    if (busy_ff != 8'h00) begin
      nxt_busy = busy_ff - 8'h01;
    end
    if (!s_rstn || sysrst_ff) begin
      // Full device reset from pin or control sequence
      nxt_lk     = lk_idle;
      nxt_mode   = otp_pkg::md_idle;
      nxt_cnt    = 4'h0;
      nxt_sel    = 8'h00;
      nxt_device_control_reg = 8'h00;
      nxt_last02 = 1'b0;
      nxt_addr   = 16'h0000;
      nxt_err    = 1'b0;
      nxt_halt   = 1'b0;
      nxt_doe_n  = 1'b1;
    end else begin
      case (lk_ff)
        lk_idle: begin
          if (rise && !s_dat) begin
            nxt_cnt = 4'h0;
            nxt_lk  = lk_ins;
          end
        end
        lk_ins: begin
          if (rise) begin
            nxt_ins = ins2;
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == 4'h1) begin
              nxt_cnt = 4'h0;
              nxt_lk  = lk_wr;
              if (otp_pkg::otp_is_read(ins2)) begin
                nxt_lk = lk_rd;
                if (ins2 == otp_pkg::IN_AR) begin
                  rb = {7'h00, busy_ff != 8'h00};
                end else begin
                  case (sel_ff)
                    otp_pkg::LA_DATA: begin
                      if (rd_ok) begin
                        rb = mem_rd;
                      end else begin
                        nxt_err = 1'b1;
                      end
                      nxt_addr = addr_ff + 16'h0001;
                    end
                    otp_pkg::LA_STAT: begin
                      rb[otp_pkg::ST_ERR] = err_ff;
                      rb[otp_pkg::ST_WP]  = wlock;
                      rb[otp_pkg::ST_RP]  = rlock;
                      nxt_err = 1'b0;
                    end
                    otp_pkg::LA_DEVICE_CONTROL_REG: rb = device_control_reg_ff;
                    otp_pkg::LA_ADDRH:  rb = addr_ff[15:8];
                    otp_pkg::LA_ADDRL:  rb = addr_ff[7:0];
                    default:            rb = 8'h00;
                  endcase
                end
                nxt_sh = rb;
              end
            end
          end
        end
        lk_wr: begin
          if (rise) begin
            nxt_sh  = wb;
            nxt_cnt = cnt_ff + 4'h1;
            if (cnt_ff == 4'h7) begin
              nxt_lk = lk_idle;
              if (ins_ff == otp_pkg::IN_AW) begin
                nxt_sel = wb;
              end else begin
                case (sel_ff)
                  otp_pkg::LA_DEVICE_CONTROL_REG: begin
                    nxt_device_control_reg = wb;
                    if (wb == otp_pkg::DC_HALT) begin
                      nxt_halt = 1'b1;
                    end
                    if (last02_ff && wb == otp_pkg::DC_RST2) begin
                      nxt_sysrst = 1'b1;
                    end
                    nxt_last02 = (wb == otp_pkg::DC_RST1);
                  end
                  otp_pkg::LA_MODE: begin
                    if (wb == otp_pkg::MM_ARM) begin
                      nxt_mode = otp_pkg::md_armed;
                    end else if (mode_ff == otp_pkg::md_armed && wb == otp_pkg::MM_PROG) begin
                      nxt_mode = otp_pkg::md_prog;
                    end else if (mode_ff == otp_pkg::md_armed && wb == otp_pkg::MM_OFF) begin
                      nxt_mode = otp_pkg::md_idle;
                    end else if (wb == otp_pkg::MM_OFF) begin
                      nxt_mode = otp_pkg::md_read;
                    end else begin
                      nxt_mode = otp_pkg::md_idle;
                    end
                  end
                  otp_pkg::LA_ADDRH: nxt_addr[15:8] = wb;
                  otp_pkg::LA_ADDRL: nxt_addr[7:0]  = wb;
                  otp_pkg::LA_DATA: begin
                    if (wr_ok) begin
                      mem_we   = 1'b1;
                      mem_wd   = wb;
                      nxt_busy = 8'(otp_pkg::PROG_CYC);
                    end else begin
                      nxt_err = 1'b1;
                    end
                    nxt_addr = addr_ff + 16'h0001;
                  end
                  default: nxt_sel = sel_ff;
                endcase
              end
            end
          end
        end
        lk_rd: begin
          if (fall) begin
            if (cnt_ff == 4'h8) begin
              nxt_doe_n = 1'b1;
              nxt_lk    = lk_idle;
            end else begin
              nxt_dout  = sh_ff[7];
              nxt_doe_n = 1'b0;
              nxt_sh    = {sh_ff[6:0], 1'b0};
              nxt_cnt   = cnt_ff + 4'h1;
            end
          end
        end
        default: nxt_lk = lk_idle;
      endcase
    end
    nxt_pmode = (nxt_mode == otp_pkg::md_prog);
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      lk_ff     <= lk_idle;
      mode_ff   <= otp_pkg::md_idle;
      cnt_ff    <= 4'h0;
      sh_ff     <= 8'h00;
      ins_ff    <= 2'h0;
      sel_ff    <= 8'h00;
      device_control_reg_ff <= 8'h00;
      last02_ff <= 1'b0;
      addr_ff   <= 16'h0000;
      err_ff    <= 1'b0;
      busy_ff   <= 8'h00;
      halt_ff   <= 1'b0;
      sysrst_ff <= 1'b0;
      dout_ff   <= 1'b1;
      doe_n_ff  <= 1'b1;
      pmode_ff  <= 1'b0;
    end else begin
      lk_ff     <= nxt_lk;
      mode_ff   <= nxt_mode;
      cnt_ff    <= nxt_cnt;
      sh_ff     <= nxt_sh;
      ins_ff    <= nxt_ins;
      sel_ff    <= nxt_sel;
      device_control_reg_ff <= nxt_device_control_reg;
      last02_ff <= nxt_last02;
      addr_ff   <= nxt_addr;
      err_ff    <= nxt_err;
      busy_ff   <= nxt_busy;
      halt_ff   <= nxt_halt;
      sysrst_ff <= nxt_sysrst;
      dout_ff   <= nxt_dout;
      doe_n_ff  <= nxt_doe_n;
      pmode_ff  <= nxt_pmode;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign lnk.d_dat      = dout_ff;
  assign lnk.d_dat_oe_n = doe_n_ff;
  assign core_halt_o    = halt_ff;
  assign prog_mode_o    = pmode_ff;
  assign sys_reset_o    = sysrst_ff;
endmodule : otp_dev

// file: design/otp_pkg.sv
// Shared constants for the one-time-programmable memory access link
package otp_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS        = 10;
  localparam int LINK_WAIT_NS  = 20000;
  localparam int LINK_WAIT_CYC = (LINK_WAIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int PIN_RST_NS    = 1000;
  localparam int PIN_RST_CYC   = (PIN_RST_NS + CLK_NS - 1) / CLK_NS;
  localparam int PROG_TIME_NS  = 1000;
  localparam int PROG_CYC      = (PROG_TIME_NS + CLK_NS - 1) / CLK_NS;
  localparam int HALF_CYC      = 8;
  localparam int GAP_CYC       = 2 * HALF_CYC;
  // ****************************************
  // Link instructions and frame
  // ****************************************
  localparam logic [1:0] IN_DR = 2'h0;
  localparam logic [1:0] IN_DW = 2'h1;
  localparam logic [1:0] IN_AR = 2'h2;
  localparam logic [1:0] IN_AW = 2'h3;
  localparam logic [3:0] FRM_LAST = 4'hA;
  localparam logic [3:0] RD_OUT   = 4'h3;
  // ****************************************
  // Device register selects and values
  // ****************************************
  localparam logic [7:0] LA_DEVICE_CONTROL_REG = 8'h00;
  localparam logic [7:0] LA_MODE   = 8'h01;
  localparam logic [7:0] LA_ADDRH  = 8'h02;
  localparam logic [7:0] LA_ADDRL  = 8'h03;
  localparam logic [7:0] LA_DATA   = 8'h04;
  localparam logic [7:0] LA_STAT   = 8'h05;
  localparam logic [7:0] DC_HALT   = 8'h04;
  localparam logic [7:0] DC_RST1   = 8'h02;
  localparam logic [7:0] DC_RST2   = 8'h00;
  localparam logic [7:0] MM_ARM    = 8'h40;
  localparam logic [7:0] MM_PROG   = 8'h58;
  localparam logic [7:0] MM_OFF    = 8'h00;
  localparam logic [7:0] ERASED    = 8'hFF;
  // Status bits: 0 error, 1 write protect, 2 read protect
  localparam int ST_ERR = 0;
  localparam int ST_WP  = 1;
  localparam int ST_RP  = 2;
  // ****************************************
  // Code memory
  // ****************************************
  localparam int          ADDR_W     = 13;
  localparam logic [15:0] CODE_BYTES = 16'h2000;
  localparam logic [12:0] SEC_ADDR   = 13'h1FFF;
  // ****************************************
  // Host register offsets
  // ****************************************
  localparam logic [3:0] HO_CMD  = 4'h0;
  localparam logic [3:0] HO_STAT = 4'h4;
  localparam logic [3:0] HO_CTRL = 4'h8;
  localparam int HC_VPP = 0;
  localparam int HC_RST = 1;

  typedef enum logic [1:0] {md_idle, md_armed, md_prog, md_read} otp_mode_t;

  function automatic logic otp_is_read(input logic [1:0] ins);
    otp_is_read = (ins[0] == 1'b0);
  endfunction : otp_is_read
endpackage : otp_pkg

// file: design/otp_link_if.sv
// Link between the programmer and the device: clock, data, supply, reset pin
`timescale 1ns/1ps
interface otp_link_if;
  logic link_clk;
  logic h_dat;
  logic h_dat_oe_n;
  logic d_dat;
  logic d_dat_oe_n;
  logic dat;
  logic vpp;
  logic rst_pin_n;

  // Open line with pull-up
  assign dat = !h_dat_oe_n ? h_dat : (!d_dat_oe_n ? d_dat : 1'b1);

  modport host (output link_clk, output h_dat, output h_dat_oe_n, output vpp,
                output rst_pin_n, input dat);
  modport dev  (input link_clk, input dat, input vpp, input rst_pin_n,
                output d_dat, output d_dat_oe_n);
endinterface : otp_link_if

// file: design/otp_host.sv
// Programmer end: Avalon-MM command registers driving the link
`timescale 1ns/1ps
module otp_host (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Link
  otp_link_if.host         lnk
);
  typedef enum logic [1:0] {hs_pinrst, hs_wait, hs_idle, hs_frame} otp_hs_t;

  // ****************************************
  // Line synchroniser
  // ****************************************
  logic sy1_ff;
  logic sy2_ff;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sy1_ff <= 1'b1;
      sy2_ff <= 1'b1;
    end else begin
      sy1_ff <= lnk.dat;
      sy2_ff <= sy1_ff;
    end
  end

  // ****************************************
  // Sequencer and registers
  // ****************************************
  otp_hs_t     st_ff, nxt_st;
  logic [11:0] tmr_ff, nxt_tmr;
  logic [3:0]  half_ff, nxt_half;
  logic [3:0]  bit_ff, nxt_bit;
  logic [10:0] frm_ff, nxt_frm;
  logic [7:0]  rx_ff, nxt_rx;
  logic        isrd_ff, nxt_isrd;
  logic        lclk_ff, nxt_lclk;
  logic        hdat_ff, nxt_hdat;
  logic        hoe_n_ff, nxt_hoe_n;
  logic        vpp_ff, nxt_vpp;
  logic        rstn_ff, nxt_rstn;
  logic        wreq_ff, nxt_wreq;
  logic [31:0] rdat_ff, nxt_rdat;
  logic        acc;
  logic        busy;

  assign acc  = (avs_read || avs_write) && !wreq_ff;
  assign busy = (st_ff != hs_idle) || (tmr_ff != 12'h000);

  always_comb begin
    nxt_st    = st_ff;
    nxt_tmr   = tmr_ff;
    nxt_half  = half_ff;
    nxt_bit   = bit_ff;
    nxt_frm   = frm_ff;
    nxt_rx    = rx_ff;
    nxt_isrd  = isrd_ff;
    nxt_lclk  = lclk_ff;
    nxt_hdat  = hdat_ff;
    nxt_hoe_n = hoe_n_ff;
    nxt_vpp   = vpp_ff;
    nxt_rstn  = rstn_ff;
    nxt_rdat  = rdat_ff;
    nxt_wreq  = !((avs_read || avs_write) && wreq_ff);
    if (tmr_ff != 12'h000) begin
      nxt_tmr = tmr_ff - 12'h001;
    end
    if (avs_read && wreq_ff) begin
      case (avs_address)
        otp_pkg::HO_STAT: nxt_rdat = {16'h0000, rx_ff, 6'h00, vpp_ff, busy};
        otp_pkg::HO_CTRL: nxt_rdat = {31'h00000000, vpp_ff};
        default:          nxt_rdat = 32'h00000000;
      endcase
    end
    case (st_ff)
      hs_pinrst: begin
        nxt_rstn = 1'b0;
        if (tmr_ff == 12'h000) begin
          nxt_rstn = 1'b1;
          nxt_tmr  = 12'(otp_pkg::LINK_WAIT_CYC);
          nxt_st   = hs_wait;
        end
      end
      hs_wait: begin
        if (tmr_ff == 12'h000) begin
          nxt_st = hs_idle;
        end
      end
      hs_idle: begin
        if (acc && avs_write && avs_address == otp_pkg::HO_CMD && tmr_ff == 12'h000) begin
          nxt_st    = hs_frame;
          nxt_frm   = {1'b0, avs_writedata[1:0], avs_writedata[15:8]};
          nxt_isrd  = otp_pkg::otp_is_read(avs_writedata[1:0]);
          nxt_bit   = 4'h0;
          nxt_half  = 4'h0;
          nxt_hdat  = 1'b0;
          nxt_hoe_n = 1'b0;
        end
      end
      hs_frame: begin
        nxt_half = half_ff + 4'h1;
        if (half_ff == 4'(otp_pkg::HALF_CYC - 1)) begin
          nxt_half = 4'h0;
          if (!lclk_ff) begin
            nxt_lclk = 1'b1;
          end else begin
            nxt_lclk = 1'b0;
            if (isrd_ff && bit_ff >= otp_pkg::RD_OUT) begin
              nxt_rx = {rx_ff[6:0], sy2_ff};
            end
            nxt_bit = bit_ff + 4'h1;
            nxt_frm = {frm_ff[9:0], 1'b1};
            if (bit_ff == otp_pkg::FRM_LAST) begin
              nxt_st    = hs_idle;
              nxt_hoe_n = 1'b1;
              nxt_tmr   = 12'(otp_pkg::GAP_CYC);
            end else if (isrd_ff && bit_ff + 4'h1 >= otp_pkg::RD_OUT) begin
              nxt_hoe_n = 1'b1;
            end else begin
              nxt_hdat = frm_ff[9];
            end
          end
        end
      end
      default: nxt_st = hs_idle;
    endcase
    if (acc && avs_write && avs_address == otp_pkg::HO_CTRL) begin
      nxt_vpp = avs_writedata[otp_pkg::HC_VPP];
      if (avs_writedata[otp_pkg::HC_RST]) begin
        nxt_st    = hs_pinrst;
        nxt_tmr   = 12'(otp_pkg::PIN_RST_CYC);
        nxt_lclk  = 1'b0;
        nxt_hoe_n = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_ff    <= hs_pinrst;
      tmr_ff   <= 12'(otp_pkg::PIN_RST_CYC);
      half_ff  <= 4'h0;
      bit_ff   <= 4'h0;
      frm_ff   <= 11'h7FF;
      rx_ff    <= 8'h00;
      isrd_ff  <= 1'b0;
      lclk_ff  <= 1'b0;
      hdat_ff  <= 1'b1;
      hoe_n_ff <= 1'b1;
      vpp_ff   <= 1'b0;
      rstn_ff  <= 1'b0;
      wreq_ff  <= 1'b1;
      rdat_ff  <= 32'h00000000;
    end else begin
      st_ff    <= nxt_st;
      tmr_ff   <= nxt_tmr;
      half_ff  <= nxt_half;
      bit_ff   <= nxt_bit;
      frm_ff   <= nxt_frm;
      rx_ff    <= nxt_rx;
      isrd_ff  <= nxt_isrd;
      lclk_ff  <= nxt_lclk;
      hdat_ff  <= nxt_hdat;
      hoe_n_ff <= nxt_hoe_n;
      vpp_ff   <= nxt_vpp;
      rstn_ff  <= nxt_rstn;
      wreq_ff  <= nxt_wreq;
      rdat_ff  <= nxt_rdat;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign avs_readdata    = rdat_ff;
  assign avs_waitrequest = wreq_ff;
  assign lnk.link_clk    = lclk_ff;
  assign lnk.h_dat       = hdat_ff;
  assign lnk.h_dat_oe_n  = hoe_n_ff;
  assign lnk.vpp         = vpp_ff;
  assign lnk.rst_pin_n   = rstn_ff;
endmodule : otp_host

// file: tb/otp_link_monitor.sv
// Link checker beside the interface joining programmer and device
`timescale 1ns/1ps
module otp_link_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link
  input wire logic link_clk,
  input wire logic h_dat_oe_n,
  input wire logic d_dat,
  input wire logic d_dat_oe_n,
  input wire logic vpp,
  input wire logic rst_pin_n,
  // Device side
  input wire logic core_halt_o,
  input wire logic prog_mode_o,
  input wire logic sys_reset_o
);
  localparam int WAIT_MIN = 1999;
  logic [11:0] wait_cnt_ff;
  logic [11:0] nxt_wait_cnt;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Cycles since the pin reset was released
  always_comb begin
    nxt_wait_cnt = wait_cnt_ff;
    if (!rst_pin_n)
      nxt_wait_cnt = 12'h000;
    else if (wait_cnt_ff != 12'hFFF)
      nxt_wait_cnt = wait_cnt_ff + 12'h001;
  end
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i)
      wait_cnt_ff <= 12'h000;
    else
      wait_cnt_ff <= nxt_wait_cnt;
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_half_hi;
    link_clk [*8] ##1 !link_clk;
  endsequence
  sequence s_pin_low;
    !rst_pin_n [*5];
  endsequence

  AST_ONE_DRIVER: assert property (!(!h_dat_oe_n && !d_dat_oe_n))
    else $error("both ends drive the data line");
  AST_FIRST_CMD_WAIT: assert property ($rose(link_clk) |-> wait_cnt_ff >= WAIT_MIN)
    else $error("link clock too soon after pin reset");
  AST_QUIET_IN_PIN_RST: assert property (!rst_pin_n |-> !link_clk && h_dat_oe_n)
    else $error("link active during pin reset");
  AST_PIN_RST_CLEARS: assert property (s_pin_low |-> !core_halt_o && !prog_mode_o)
    else $error("pin reset did not clear device");
  AST_SYS_RST_EFFECT: assert property (sys_reset_o |=> !sys_reset_o && !core_halt_o)
    else $error("device reset pulse wrong");
  AST_PROG_NEEDS_HALT: assert property (prog_mode_o |-> core_halt_o)
    else $error("program mode without halted core");
  AST_SUPPLY_IN_PROG: assert property ($rose(vpp) |-> prog_mode_o)
    else $error("supply raised outside program mode");
  AST_SUPPLY_OFF_FIRST: assert property ($fell(prog_mode_o) |-> !vpp)
    else $error("program mode left with supply on");
  AST_LINK_HALF: assert property ($rose(link_clk) |-> s_half_hi)
    else $error("link clock high phase wrong");
  AST_DEV_BIT_HOLD: assert property (!d_dat_oe_n && link_clk |-> $stable(d_dat))
    else $error("device bit changed while clock high");
  AST_DEV_DRIVE_LOW: assert property ($fell(d_dat_oe_n) |-> !link_clk)
    else $error("device took the line while clock high");
endmodule : otp_link_monitor

// file: tb/tb_otp_code_memory_program_read.sv
// Testbench: programmer and device ends joined over the link
`timescale 1ns/1ps
module tb_otp_code_memory_program_read;
  logic        clk_i;
  logic        rst_i;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        core_halt_o;
  logic        prog_mode_o;
  logic        sys_reset_o;
  int          n_mismatch = 0;
  int          checks_done = 0;
  int          n_pulse = 0;
  logic [7:0]  q8;
  logic [31:0] q32;
  logic [15:0] rows [3] = '{16'hA5A5, 16'h3C3C, 16'h8181};

  otp_link_if otp_link_if_i ();
  otp_host otp_host_i (.clk_i(clk_i), .rst_i(rst_i), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .lnk(otp_link_if_i));
  otp_dev otp_dev_i (.clk_i(clk_i), .rst_i(rst_i), .lnk(otp_link_if_i),
    .core_halt_o(core_halt_o), .prog_mode_o(prog_mode_o), .sys_reset_o(sys_reset_o));
  otp_link_monitor otp_link_monitor_i (.clk_i(clk_i), .rst_i(rst_i),
    .link_clk(otp_link_if_i.link_clk), .h_dat_oe_n(otp_link_if_i.h_dat_oe_n),
    .d_dat(otp_link_if_i.d_dat), .d_dat_oe_n(otp_link_if_i.d_dat_oe_n),
    .vpp(otp_link_if_i.vpp), .rst_pin_n(otp_link_if_i.rst_pin_n),
    .core_halt_o(core_halt_o), .prog_mode_o(prog_mode_o), .sys_reset_o(sys_reset_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (sys_reset_o === 1'b1) n_pulse++;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic close_out();
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    @(posedge clk_i);
    while (avs_waitrequest !== 1'b0) @(posedge clk_i);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge clk_i);
  endtask : av
  task automatic req(input logic [3:0] a, input logic [31:0] d, output logic [7:0] r);
    logic [31:0] s;
    av(1'b1, a, d, s);
    s = 32'h1;
    while (s[0] !== 1'b0) av(1'b0, otp_pkg::HO_STAT, 32'h0, s);
    r = s[15:8];
  endtask : req
  function automatic logic [31:0] cw(input logic [1:0] i, input logic [7:0] b);
    cw = {16'h0000, b, 6'h00, i};
  endfunction : cw
  task automatic wreg(input logic [7:0] sel, input logic [7:0] v);
    req(otp_pkg::HO_CMD, cw(otp_pkg::IN_AW, sel), q8);
    req(otp_pkg::HO_CMD, cw(otp_pkg::IN_DW, v), q8);
  endtask : wreg
  task automatic rreg(input logic [7:0] sel, output logic [7:0] v);
    req(otp_pkg::HO_CMD, cw(otp_pkg::IN_AW, sel), v);
    req(otp_pkg::HO_CMD, cw(otp_pkg::IN_DR, 8'h00), v);
  endtask : rreg
  task automatic addr(input logic [15:0] a);
    wreg(otp_pkg::LA_ADDRH, a[15:8]);
    wreg(otp_pkg::LA_ADDRL, a[7:0]);
  endtask : addr
  task automatic wdat(input logic [7:0] v);
    logic [7:0] r;
    wreg(otp_pkg::LA_DATA, v);
    r = 8'h01;
    while (r[0] !== 1'b0) req(otp_pkg::HO_CMD, cw(otp_pkg::IN_AR, 8'h00), r);
  endtask : wdat
  task automatic stat(input string nm, input logic [2:0] e);
    logic [7:0] v;
    rreg(otp_pkg::LA_STAT, v);
    chk(nm, v[2:0], e);
  endtask : stat
  task automatic mode(input logic [7:0] a, input logic [7:0] b);
    wreg(otp_pkg::LA_MODE, a);
    wreg(otp_pkg::LA_MODE, b);
  endtask : mode

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    rst_i = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    req(otp_pkg::HO_CTRL, 32'h2, q8);
    wreg(otp_pkg::LA_DEVICE_CONTROL_REG, otp_pkg::DC_HALT);
    chk("halt", core_halt_o, 1'b1);
    wreg(otp_pkg::LA_MODE, otp_pkg::MM_ARM);
    chk("armed", prog_mode_o, 1'b0);
    wreg(otp_pkg::LA_MODE, otp_pkg::MM_PROG);
    chk("prog", prog_mode_o, 1'b1);
    addr(16'h00FF);
    wdat(8'h11);
    stat("no supply", 3'b001);
    req(otp_pkg::HO_CTRL, 32'h1, q8);
    av(1'b0, otp_pkg::HO_CTRL, 32'h0, q32);
    chk("supply on", q32, 32'h1);
    addr(16'h00FF);
    foreach (rows[i]) wdat(rows[i][15:8]);
    addr(16'h00FF);
    wdat(8'h00);
    stat("rewrite", 3'b001);
    stat("cleared", 3'b000);
    req(otp_pkg::HO_CTRL, 32'h0, q8);
    mode(otp_pkg::MM_ARM, otp_pkg::MM_OFF);
    chk("left", prog_mode_o, 1'b0);
    wreg(otp_pkg::LA_MODE, otp_pkg::MM_OFF);
    addr(16'h00FF);
    foreach (rows[i]) begin
      rreg(otp_pkg::LA_DATA, q8);
      chk("read", q8, rows[i][7:0]);
    end
    mode(otp_pkg::MM_ARM, otp_pkg::MM_PROG);
    req(otp_pkg::HO_CTRL, 32'h1, q8);
    addr({3'h0, otp_pkg::SEC_ADDR});
    wdat(8'h00);
    stat("locked", 3'b110);
    addr(16'h0200);
    wdat(8'h77);
    stat("write lock", 3'b111);
    addr(16'h00FF);
    rreg(otp_pkg::LA_DATA, q8);
    stat("read lock", 3'b111);
    req(otp_pkg::HO_CTRL, 32'h0, q8);
    mode(otp_pkg::MM_ARM, otp_pkg::MM_OFF);
    wreg(otp_pkg::LA_DEVICE_CONTROL_REG, otp_pkg::DC_RST1);
    wreg(otp_pkg::LA_DEVICE_CONTROL_REG, otp_pkg::DC_RST2);
    chk("reset pulses", n_pulse, 32'h1);
    chk("released", core_halt_o, 1'b0);
    wreg(otp_pkg::LA_DEVICE_CONTROL_REG, otp_pkg::DC_HALT);
    stat("lock kept", 3'b110);
    // Mid-run reset clears halt and bus handshake
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("rst halt", core_halt_o, 1'b0);
    chk("rst wait", avs_waitrequest, 1'b1);
    close_out();
  end

  initial begin
    repeat (80000) @(posedge clk_i);
    n_mismatch++;
    close_out();
  end
endmodule : tb_otp_code_memory_program_read
